/* File: inc/aeb_cfg.svh */
`ifndef AEB_CFG_SVH
`define AEB_CFG_SVH
// Register offsets (byte addresses)
`define AEB_OFF_START    12'h000
`define AEB_OFF_ABORT    12'h004
`define AEB_OFF_DONEFLG  12'h100
`define AEB_OFF_ABRTFLG  12'h104
`define AEB_OFF_IENSET   12'h304
`define AEB_OFF_IENCLR   12'h308
`define AEB_OFF_PTR      12'h504
// Bit positions in enable registers and flag/task registers
`define AEB_BIT_DONE     0
`define AEB_BIT_ABORT    1
`define AEB_BIT_TASK     0
// Reset values
`define AEB_RST_PTR      32'h0000_0000
`define AEB_RST_IEN      2'h0
// Data structure byte offsets
`define AEB_STRUCT_KEY   32'h0000_0000
`define AEB_STRUCT_TEXT  32'h0000_0010
`define AEB_STRUCT_OUT   32'h0000_0020
// Timing
`define AEB_CLK_NS       50
`define AEB_TECB_NS      6000
`define AEB_TECB_CYC     (`AEB_TECB_NS / `AEB_CLK_NS)
`define AEB_CORE_LIMIT   (4 * `AEB_TECB_CYC)
`endif

/* File: inc/aeb_pkg.sv */
/*
 Types for the block encrypt front end.
 Assumes aeb_cfg.svh is on the include path.
*/
`include "aeb_cfg.svh"
package aeb_pkg;
    typedef enum logic [2:0] {
        AEB_IDLE, AEB_FETCH, AEB_KICK, AEB_WAIT, AEB_STORE
    } aeb_state_t;

    typedef struct packed {
        aeb_state_t   st;
        logic [2:0]   widx;
        logic [127:0] key;
        logic [127:0] txt;
        logic [9:0]   tmr;
        logic         done_flg;
        logic         abrt_flg;
        logic [1:0]   ien;
        logic [31:0]  ptr;
        logic [31:0]  prdata;
        logic         irq;
    } aeb_regs_t;
endpackage

/* File: src/aeb_ctrl.sv */
/*
 Control front end of a pointer-driven 128-bit block encryptor: APB register
 file, DMA word master towards data RAM, handshake to a shared cipher core.
 Assumes a single clock, RAM answering dma_ack at any later cycle, and a core
 that reports other users on core_busy.
*/
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ns
module aeb_ctrl
    import aeb_pkg::*;
(
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // APB slave
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    // DMA word master
    output logic              dma_req,
    output logic              dma_we,
    output logic [31:0]       dma_addr,
    output logic [31:0]       dma_wdata,
    input  wire logic         dma_ack,
    input  wire logic [31:0]  dma_rdata,
    // Shared cipher core
    output logic              core_start,
    output logic [127:0]      core_key,
    output logic [127:0]      core_text,
    input  wire logic         core_busy,
    input  wire logic         core_done,
    input  wire logic [127:0] core_result,
    // Interrupt
    output logic              irq
);
    localparam logic [9:0] CORE_LIMIT = 10'(`AEB_CORE_LIMIT);

    aeb_regs_t r_r;
    aeb_regs_t r_nxt;

    logic wr_en;
    logic setup;
    logic mapped;
    logic start_tk;
    logic abort_tk;
    logic last_fetch;
    logic last_store;

    assign wr_en  = psel && penable && pwrite;
    assign setup  = psel && !penable;
    assign mapped = paddr == `AEB_OFF_START || paddr == `AEB_OFF_ABORT
                 || paddr == `AEB_OFF_DONEFLG || paddr == `AEB_OFF_ABRTFLG
                 || paddr == `AEB_OFF_IENSET || paddr == `AEB_OFF_IENCLR
                 || paddr == `AEB_OFF_PTR;
    assign start_tk = wr_en && paddr == `AEB_OFF_START && pwdata[`AEB_BIT_TASK];
    assign abort_tk = wr_en && paddr == `AEB_OFF_ABORT && pwdata[`AEB_BIT_TASK];
    assign last_fetch = r_r.st == AEB_FETCH && dma_ack && r_r.widx == 3'h7;
    assign last_store = r_r.st == AEB_STORE && dma_ack && r_r.widx == 3'h3;

    // Zero-wait slave; read data is captured in the setup phase
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata  = r_r.prdata;
    assign irq     = r_r.irq;

    assign dma_req   = r_r.st == AEB_FETCH || r_r.st == AEB_STORE;
    assign dma_we    = r_r.st == AEB_STORE;
    assign dma_wdata = r_r.txt[32*r_r.widx[1:0] +: 32];
    assign core_start = r_r.st == AEB_KICK;
    assign core_key   = r_r.key;
    assign core_text  = r_r.txt;

    always_comb begin
        logic [31:0] base;
        base = r_r.st == AEB_STORE ? `AEB_STRUCT_OUT : `AEB_STRUCT_KEY;
        // Key words 0..3 then cleartext words 4..7 lie back to back
        dma_addr = r_r.ptr + base + {27'h0, r_r.widx, 2'b00};
    end

    always_comb begin
        logic ev_done;
        logic ev_abort;
        ev_done  = 1'b0;
        ev_abort = 1'b0;
        r_nxt = r_r;

        // Sequencer
        unique case (r_r.st)
            AEB_IDLE: begin
                if (start_tk) begin
                    if (core_busy) begin
                        ev_abort = 1'b1;
                    end else begin
                        r_nxt.st   = AEB_FETCH;
                        r_nxt.widx = 3'h0;
                    end
                end
            end
            AEB_FETCH: begin
                if (dma_ack) begin
                    if (r_r.widx[2]) begin
                        r_nxt.txt[32*r_r.widx[1:0] +: 32] = dma_rdata;
                    end else begin
                        r_nxt.key[32*r_r.widx[1:0] +: 32] = dma_rdata;
                    end
                    r_nxt.widx = r_r.widx + 3'h1;
                    if (last_fetch) begin
                        r_nxt.st = AEB_KICK;
                    end
                end
            end
            AEB_KICK: begin
                r_nxt.tmr = 10'h0;
                r_nxt.st  = AEB_WAIT;
            end
            AEB_WAIT: begin
                r_nxt.tmr = r_r.tmr + 10'h1;
                if (core_done) begin
                    r_nxt.txt  = core_result;
                    r_nxt.widx = 3'h0;
                    r_nxt.st   = AEB_STORE;
                end else if (r_r.tmr == CORE_LIMIT) begin
                    // Core never answered; treat as an error abort
                    ev_abort = 1'b1;
                    r_nxt.st = AEB_IDLE;
                end
            end
            AEB_STORE: begin
                if (dma_ack) begin
                    r_nxt.widx = r_r.widx + 3'h1;
                    if (last_store) begin
                        ev_done  = 1'b1;
                        r_nxt.st = AEB_IDLE;
                    end
                end
            end
        endcase

        // Start while already running is refused; current block goes on
        if (start_tk && r_r.st != AEB_IDLE) begin
            ev_abort = 1'b1;
        end
        // Abort overrides everything else in flight
        if (abort_tk && r_r.st != AEB_IDLE) begin
            ev_abort = 1'b1;
            ev_done  = 1'b0;
            r_nxt.st = AEB_IDLE;
        end

        // Register writes
        if (wr_en) begin
            unique case (paddr)
                `AEB_OFF_DONEFLG: r_nxt.done_flg = pwdata[0];
                `AEB_OFF_ABRTFLG: r_nxt.abrt_flg = pwdata[0];
                `AEB_OFF_IENSET:  r_nxt.ien = r_r.ien | pwdata[1:0];
                `AEB_OFF_IENCLR:  r_nxt.ien = r_r.ien & ~pwdata[1:0];
                `AEB_OFF_PTR:     r_nxt.ptr = pwdata;
                default: ;
            endcase
        end
        // Hardware set wins over a software clear in the same cycle
        if (ev_done) begin
            r_nxt.done_flg = 1'b1;
        end
        if (ev_abort) begin
            r_nxt.abrt_flg = 1'b1;
        end

        // Read data captured during setup
        if (setup) begin
            unique case (paddr)
                `AEB_OFF_DONEFLG: r_nxt.prdata = {31'h0, r_r.done_flg};
                `AEB_OFF_ABRTFLG: r_nxt.prdata = {31'h0, r_r.abrt_flg};
                `AEB_OFF_IENSET,
                `AEB_OFF_IENCLR:  r_nxt.prdata = {30'h0, r_r.ien};
                `AEB_OFF_PTR:     r_nxt.prdata = r_r.ptr;
                default:          r_nxt.prdata = 32'h0;
            endcase
        end

        r_nxt.irq = (r_nxt.done_flg && r_nxt.ien[`AEB_BIT_DONE])
                 || (r_nxt.abrt_flg && r_nxt.ien[`AEB_BIT_ABORT]);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_r <= '{st: AEB_IDLE, widx: 3'h0, key: 128'h0, txt: 128'h0,
                     tmr: 10'h0, done_flg: 1'b0, abrt_flg: 1'b0,
                     ien: `AEB_RST_IEN, ptr: `AEB_RST_PTR,
                     prdata: 32'h0, irq: 1'b0};
        end else begin
            r_r <= r_nxt;
        end
    end

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_store_end;
        r_r.st == AEB_STORE && dma_ack && r_r.widx == 3'h3;
    endsequence

    sequence s_run_abort;
        abort_tk && r_r.st != AEB_IDLE;
    endsequence

    chk_abort_task_flag: assert property (
        s_run_abort |=> r_r.abrt_flg && r_r.st == AEB_IDLE)
        else $error("abort task did not stop and flag");

    chk_busy_start_refused: assert property (
        r_r.st == AEB_IDLE && start_tk && core_busy |=> r_r.st == AEB_IDLE && r_r.abrt_flg)
        else $error("start on busy core was not refused");

    chk_abort_flag_hold: assert property (
        r_r.abrt_flg && !(wr_en && paddr == `AEB_OFF_ABRTFLG) |=> r_r.abrt_flg)
        else $error("abort flag lost without clear");

    chk_ien_set_done: assert property (
        wr_en && paddr == `AEB_OFF_IENSET && pwdata[0] |=> r_r.ien[0])
        else $error("done interrupt not enabled");

    chk_ien_set_zero: assert property (
        wr_en && paddr == `AEB_OFF_IENSET && !pwdata[1] |=> r_r.ien[1] == $past(r_r.ien[1]))
        else $error("writing zero changed abort enable");

    chk_ien_clr_done: assert property (
        wr_en && paddr == `AEB_OFF_IENCLR && pwdata[0] |=> !r_r.ien[0])
        else $error("done interrupt not disabled");

    chk_ien_clr_abort: assert property (
        wr_en && paddr == `AEB_OFF_IENCLR && pwdata[1] |=> !r_r.ien[1])
        else $error("abort interrupt not disabled");

    chk_dma_in_struct: assert property (
        dma_req |-> dma_addr - r_r.ptr <= 32'h0000_002c
                 && (dma_we == (dma_addr - r_r.ptr >= `AEB_STRUCT_OUT)))
        else $error("DMA address outside structure");

    chk_done_after_store: assert property (
        s_store_end ##0 !abort_tk |=> r_r.done_flg && r_r.st == AEB_IDLE)
        else $error("done not flagged after write-back");

    chk_core_bound: assert property (
        r_r.st == AEB_WAIT && r_r.tmr == CORE_LIMIT && !core_done
        |=> r_r.st == AEB_IDLE && r_r.abrt_flg)
        else $error("silent core not turned into an abort");

    chk_irq_level: assert property (
        irq == ((r_r.done_flg && r_r.ien[0]) || (r_r.abrt_flg && r_r.ien[1])))
        else $error("interrupt level wrong");
endmodule

/* File: tb/aeb_ram_model.sv */
/*
 Data RAM seen through the encryptor's DMA word port.
 Assumes word-aligned byte addresses; only 64 words, so addresses wrap.
*/
`timescale 1ns/1ns
module aeb_ram_model (
    // Clock
    input  wire logic        pclk,
    // DMA slave
    input  wire logic        dma_req,
    input  wire logic        dma_we,
    input  wire logic [31:0] dma_addr,
    input  wire logic [31:0] dma_wdata,
    output logic             dma_ack,
    output logic [31:0]      dma_rdata
);
    logic [31:0] mem [0:63];
    logic [1:0]  wait_cnt = 2'h0;
    logic        slow     = 1'b0;

    initial dma_ack = 1'b0;
    initial dma_rdata = 32'h0;

    // Alternates prompt and slow answers to stress the request hold
    always @(posedge pclk) begin
        dma_ack <= 1'b0;
        // Data line not held outside an answer
        dma_rdata <= ~dma_rdata;
        if (dma_req && !dma_ack) begin
            if (wait_cnt != 2'h0) begin
                wait_cnt <= wait_cnt - 2'h1;
            end else begin
                dma_ack  <= 1'b1;
                slow     <= !slow;
                wait_cnt <= slow ? 2'h0 : 2'h2;
                if (dma_we) begin
                    mem[dma_addr[7:2]] <= dma_wdata;
                end else begin
                    dma_rdata <= mem[dma_addr[7:2]];
                end
            end
        end
    end
endmodule

/* File: tb/tb_top.sv */
/*
 Self-checking bench of the block encrypt front end: APB tasks, a core
 stand-in returning key minus text, and the RAM model.
 Assumes aeb_cfg.svh on the include path and the package compiled first.
*/
`timescale 1ns/1ns
`include "aeb_cfg.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
    $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_top;
    logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic         dma_req, dma_we, dma_ack, core_start, core_busy;
    logic         core_done = 1'b0, core_mute = 1'b0;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, q, dma_addr, dma_wdata, dma_rdata;
    logic [127:0] core_key, core_text, k, t;
    logic [127:0] core_result = '0;
    logic [6:0]   core_cnt = 7'h0;
    int           n_errors = 0, checks_done = 0, cyc = 0, t0;

    aeb_ctrl i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .dma_req(dma_req), .dma_we(dma_we),
        .dma_addr(dma_addr), .dma_wdata(dma_wdata), .dma_ack(dma_ack),
        .dma_rdata(dma_rdata), .core_start(core_start), .core_key(core_key),
        .core_text(core_text), .core_busy(core_busy), .core_done(core_done),
        .core_result(core_result), .irq(irq)
    );
    aeb_ram_model i_ram (
        .pclk(pclk), .dma_req(dma_req), .dma_we(dma_we), .dma_addr(dma_addr),
        .dma_wdata(dma_wdata), .dma_ack(dma_ack), .dma_rdata(dma_rdata)
    );

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // Subtraction, not xor, so swapped key and text would show
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        core_done <= 1'b0;
        if (core_start) begin
            core_cnt <= 7'h64;
        end else if (core_cnt != 7'h0) begin
            core_cnt <= core_cnt - 7'h1;
        end
        // Mute stands in for a core that never answers
        if (core_cnt == 7'h1 && !core_mute) begin
            core_done   <= 1'b1;
            core_result <= core_key - core_text;
        end
        if (cyc == 5000) begin
            n_errors++;
            summarize();
        end
    end

    function automatic logic [31:0] pat(int i);
        return 32'h1357_9bdf * (i + 1);
    endfunction

    task automatic summarize();
        if (n_errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Starts one edge late so psel is never reassigned in one time step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(q, e)
    endtask

    task automatic wait_irq();
        t0 = cyc;
        while (irq !== 1'b1 && cyc - t0 < 2000) @(posedge pclk);
        `CHK(irq, 1'b1)
    endtask

    task automatic look();
        @(posedge pclk);
        @(negedge pclk);
    endtask

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, core_busy} = 4'h0;
        {paddr, pwdata} = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(`AEB_OFF_PTR, 32'h0);
        rd(`AEB_OFF_ABRTFLG, 32'h0);
        wr(`AEB_OFF_IENSET, 32'h1);
        rd(`AEB_OFF_IENSET, 32'h1);
        wr(`AEB_OFF_IENSET, 32'h2);
        wr(`AEB_OFF_IENSET, 32'h0);
        rd(`AEB_OFF_IENCLR, 32'h3);
        wr(`AEB_OFF_IENCLR, 32'h1);
        rd(`AEB_OFF_IENSET, 32'h2);
        wr(`AEB_OFF_IENCLR, 32'h2);
        rd(`AEB_OFF_IENCLR, 32'h0);
        apb(1'b0, 12'h200, 32'h0);
        `CHK(err, 1'b1)
        for (int i = 0; i < 8; i++) begin
            i_ram.mem[16 + i] = pat(i);
        end
        for (int i = 0; i < 4; i++) begin
            k[32 * i +: 32] = pat(i);
            t[32 * i +: 32] = pat(i + 4);
        end
        wr(`AEB_OFF_PTR, 32'h40);
        rd(`AEB_OFF_PTR, 32'h40);
        wr(`AEB_OFF_IENSET, 32'h1);
        wr(`AEB_OFF_START, 32'h1);
        wait_irq();
        `CHK(cyc - t0 < 240, 1'b1)
        `CHK({i_ram.mem[27], i_ram.mem[26], i_ram.mem[25], i_ram.mem[24]}, k - t)
        rd(`AEB_OFF_DONEFLG, 32'h1);
        rd(`AEB_OFF_ABRTFLG, 32'h0);
        wr(`AEB_OFF_IENCLR, 32'h1);
        look();
        `CHK(irq, 1'b0)
        wr(`AEB_OFF_DONEFLG, 32'h0);
        wr(`AEB_OFF_IENSET, 32'h2);
        wr(`AEB_OFF_START, 32'h1);
        repeat (20) @(posedge pclk);
        wr(`AEB_OFF_ABORT, 32'h1);
        wait_irq();
        `CHK(dma_req, 1'b0)
        repeat (150) @(posedge pclk);
        rd(`AEB_OFF_DONEFLG, 32'h0);
        rd(`AEB_OFF_ABRTFLG, 32'h1);
        wr(`AEB_OFF_ABRTFLG, 32'h0);
        look();
        `CHK(irq, 1'b0)
        @(posedge pclk);
        core_busy <= 1'b1;
        wr(`AEB_OFF_START, 32'h1);
        wait_irq();
        core_busy <= 1'b0;
        repeat (150) @(posedge pclk);
        rd(`AEB_OFF_DONEFLG, 32'h0);
        core_mute <= 1'b1;
        wr(`AEB_OFF_ABRTFLG, 32'h0);
        wr(`AEB_OFF_START, 32'h1);
        wait_irq();
        `CHK(cyc - t0 > 480, 1'b1)
        rd(`AEB_OFF_DONEFLG, 32'h0);
        summarize();
    end
endmodule
